// >>> hdl/chan_status.sv
// per-channel dma status register with sticky event flags
// assumes event strobes are one-cycle pulses from clk logic, done pin is async
//
// The placing of the registers and register access over AXI4-Lite were decided locally.

`timescale 1ns/1ps
`default_nettype none

module chan_status (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // axi4-lite write address
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // transfer engine events
    input wire logic bus_owned,
    input wire logic chain_done_evt,
    input wire logic xfer_done_evt,
    input wire logic cfg_error_evt,
    input wire logic desc_bus_error_evt,
    input wire logic dest_bus_error_evt,
    input wire logic src_bus_error_evt,
    input wire logic done_drive_req,
    // done strobe pin
    input wire logic done_strobe_n_in,
    output logic done_strobe_n_out,
    output logic done_strobe_oe_n,
    // interrupt
    output logic irq
);

    // ----------------------------------------
    // state
    // ----------------------------------------
    logic [31:0] control_q;
    logic [7:0] mask_q;
    logic [7:0] flags_q;
    logic [1:0] done_sync_q;
    logic done_prev_q;
    logic [3:0] aw_addr_q;
    logic aw_full_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic w_full_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic rvalid_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic stall_event;
    logic do_write;
    logic [7:0] set_vec;
    logic [7:0] clr_vec;
    logic [15:0] status_word;
    logic ext_done_evt;
    logic self_done_evt;

    // ----------------------------------------
    // done strobe pin
    // ----------------------------------------
    // pin driven low only in bidirectional mode; oe low means driving
    assign done_strobe_n_out = 1'b0;
    assign done_strobe_oe_n = !(control_q[chan_status_pkg::CTL_DONE_BIDIR] && done_drive_req);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            done_sync_q <= 2'b11;
            done_prev_q <= 1'b1;
        end else begin
            done_sync_q <= {done_sync_q[0], done_strobe_n_in};
            done_prev_q <= done_sync_q[1];
        end
    end

    // falling edge of the synchronised pin
    assign ext_done_evt = done_prev_q && !done_sync_q[1];
    assign self_done_evt = control_q[chan_status_pkg::CTL_DONE_BIDIR] && done_drive_req;

    // ----------------------------------------
    // stall detection
    // ----------------------------------------
    stall_timer u_stall (
        .clk(clk),
        .arst_n(arst_n),
        .io_request_mode(control_q[chan_status_pkg::CTL_IO_REQ]),
        .bus_owned(bus_owned),
        .stall_flag(flags_q[7]),
        .stall_interval_setting(control_q[chan_status_pkg::CTL_STALL_LSB +: 16]),
        .stall_event(stall_event)
    );

    // ----------------------------------------
    // axi4-lite write path
    // ----------------------------------------
    assign s_axi_awready = !aw_full_q;
    assign s_axi_wready = !w_full_q;
    assign do_write = aw_full_q && w_full_q && !bvalid_q;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            aw_full_q <= 1'b0;
            aw_addr_q <= 4'h0;
        end else if (s_axi_awvalid && !aw_full_q) begin
            aw_full_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
        end else if (do_write) begin
            aw_full_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            w_full_q <= 1'b0;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
        end else if (s_axi_wvalid && !w_full_q) begin
            w_full_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
        end else if (do_write) begin
            w_full_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            bvalid_q <= 1'b0;
            bresp_q <= 2'b00;
        end else if (do_write) begin
            bvalid_q <= 1'b1;
            bresp_q <= (aw_addr_q == chan_status_pkg::ADDR_STATUS ||
                        aw_addr_q == chan_status_pkg::ADDR_CONTROL ||
                        aw_addr_q == chan_status_pkg::ADDR_IRQ_MASK) ? 2'b00 : 2'b10;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            control_q <= chan_status_pkg::CONTROL_RST;
        end else if (do_write && aw_addr_q == chan_status_pkg::ADDR_CONTROL) begin
            for (int b = 0; b < 4; b++) begin
                if (w_strb_q[b]) begin
                    control_q[b*8 +: 8] <= w_data_q[b*8 +: 8];
                end
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mask_q <= chan_status_pkg::MASK_RST;
        end else if (do_write && aw_addr_q == chan_status_pkg::ADDR_IRQ_MASK) begin
            // each lane moves on its own strobe, as the status clear does
            if (w_strb_q[0]) begin
                mask_q[6:0] <= w_data_q[6:0];
            end
            if (w_strb_q[1]) begin
                mask_q[7] <= w_data_q[chan_status_pkg::BIT_STALL];
            end
        end
    end

    // ----------------------------------------
    // sticky flags: [7]=stall, [6:0]=bits 6..0
    // ----------------------------------------
    assign set_vec = {stall_event, chain_done_evt, xfer_done_evt,
                      ext_done_evt || self_done_evt, cfg_error_evt,
                      desc_bus_error_evt, dest_bus_error_evt, src_bus_error_evt};

    // flags 6..0 clear through byte lane 0, the stall flag (bit 9) through lane 1
    always_comb begin
        clr_vec = 8'h00;
        if (do_write && aw_addr_q == chan_status_pkg::ADDR_STATUS) begin
            if (w_strb_q[1]) begin
                clr_vec[7] = w_data_q[chan_status_pkg::BIT_STALL];
            end
            if (w_strb_q[0]) begin
                clr_vec[6:0] = w_data_q[6:0];
            end
        end
    end

    // set wins over a same-cycle clear
    genvar gi;
    generate
        for (gi = 0; gi < chan_status_pkg::NUM_EVENTS; gi++) begin : g_flag
            always_ff @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    flags_q[gi] <= 1'b0;
                end else if (set_vec[gi]) begin
                    flags_q[gi] <= 1'b1;
                end else if (clr_vec[gi]) begin
                    flags_q[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // status word and interrupt
    // ----------------------------------------
    always_comb begin
        status_word = 16'h0000;
        status_word[chan_status_pkg::BIT_CHAIN_EN] = control_q[chan_status_pkg::CTL_CHAIN_EN];
        status_word[chan_status_pkg::BIT_STALL] = flags_q[7];
        status_word[chan_status_pkg::BIT_XFER_ACT] = control_q[chan_status_pkg::CTL_XFER_ACT];
        status_word[chan_status_pkg::BIT_ERR_DONE] = |flags_q[3:0];
        status_word[6:0] = flags_q[6:0];
    end

    assign irq = |(flags_q & mask_q);

    // ----------------------------------------
    // axi4-lite read path
    // ----------------------------------------
    assign s_axi_arready = !rvalid_q;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= 2'b00;
        end else if (s_axi_arvalid && !rvalid_q) begin
            rvalid_q <= 1'b1;
            rresp_q <= 2'b00;
            case (s_axi_araddr)
                chan_status_pkg::ADDR_STATUS: rdata_q <= {16'h0000, status_word};
                chan_status_pkg::ADDR_CONTROL: rdata_q <= control_q;
                chan_status_pkg::ADDR_IRQ_MASK: rdata_q <= {22'h00_0000, mask_q[7], 2'b00, mask_q[6:0]};
                default: begin
                    rdata_q <= 32'h0000_0000;
                    rresp_q <= 2'b10;
                end
            endcase
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    sequence s_w1c_write(int pos);
        do_write && aw_addr_q == chan_status_pkg::ADDR_STATUS && w_data_q[pos];
    endsequence

    chk_chain_en_mirror: assert property (@(posedge clk) disable iff (!arst_n)
        status_word[10] == control_q[0]) else $error("chain enable mirror wrong");
    chk_xfer_act_mirror: assert property (@(posedge clk) disable iff (!arst_n)
        status_word[8] == control_q[1]) else $error("transfer active mirror wrong");
    chk_error_summary: assert property (@(posedge clk) disable iff (!arst_n)
        $rose(|flags_q[3:0]) |-> status_word[7]) else $error("error summary not set");
    chk_stall_sets: assert property (@(posedge clk) disable iff (!arst_n)
        stall_event |=> flags_q[7]) else $error("stall flag not set");
    chk_stall_clear: assert property (@(posedge clk) disable iff (!arst_n)
        ((flags_q[7] && !stall_event && w_strb_q[1]) ##0 s_w1c_write(9)) |=> !flags_q[7])
        else $error("stall flag not cleared");
    chk_chain_done_set: assert property (@(posedge clk) disable iff (!arst_n)
        chain_done_evt |=> status_word[6]) else $error("chain done not set");
    chk_xfer_done_set: assert property (@(posedge clk) disable iff (!arst_n)
        xfer_done_evt |=> status_word[5]) else $error("transfer done not set");
    chk_ext_done_set: assert property (@(posedge clk) disable iff (!arst_n)
        $fell(done_sync_q[1]) |=> flags_q[4]) else $error("external done not set");
    chk_self_done_set: assert property (@(posedge clk) disable iff (!arst_n)
        (control_q[3] && done_drive_req) |=> flags_q[4]) else $error("self done not set");
    chk_cfg_err_set: assert property (@(posedge clk) disable iff (!arst_n)
        cfg_error_evt |=> flags_q[3] && status_word[7]) else $error("config error not set");
    chk_desc_err_set: assert property (@(posedge clk) disable iff (!arst_n)
        desc_bus_error_evt |=> flags_q[2]) else $error("descriptor error not set");
    chk_dest_err_set: assert property (@(posedge clk) disable iff (!arst_n)
        dest_bus_error_evt |=> flags_q[1]) else $error("dest error not set");
    chk_src_err_set: assert property (@(posedge clk) disable iff (!arst_n)
        src_bus_error_evt |=> flags_q[0]) else $error("source error not set");
    chk_reserved_zero: assert property (@(posedge clk) disable iff (!arst_n)
        status_word[15:11] == 5'h00) else $error("reserved bits not zero");
    chk_stall_halt: assert property (@(posedge clk) disable iff (!arst_n)
        flags_q[7] |-> !stall_event) else $error("stall counter ran while flagged");
    chk_chain_nochain: assert property (@(posedge clk) disable iff (!arst_n)
        (chain_done_evt && !control_q[0]) |=> flags_q[6]) else $error("plain done lost");

    chk_flags_hold: assert property (@(posedge clk) disable iff (!arst_n)
        (set_vec == 8'h00 && !(do_write && aw_addr_q == chan_status_pkg::ADDR_STATUS))
        |=> $stable(flags_q)) else $error("sticky flag changed on its own");
    chk_w0_no_clear: assert property (@(posedge clk) disable iff (!arst_n)
        (flags_q[6] && do_write && aw_addr_q == chan_status_pkg::ADDR_STATUS && !w_data_q[6])
        |=> flags_q[6]) else $error("writing zero cleared chain done");
    chk_dest_clear: assert property (@(posedge clk) disable iff (!arst_n)
        ((flags_q[1] && !dest_bus_error_evt && w_strb_q[0]) ##0 s_w1c_write(1))
        |=> !flags_q[1]) else $error("dest error not cleared");
    chk_ext_clear: assert property (@(posedge clk) disable iff (!arst_n)
        ((flags_q[4] && !ext_done_evt && !self_done_evt && w_strb_q[0]) ##0 s_w1c_write(4))
        |=> !flags_q[4]) else $error("external done not cleared");
    chk_oe_idle: assert property (@(posedge clk) disable iff (!arst_n)
        !control_q[chan_status_pkg::CTL_DONE_BIDIR] |-> done_strobe_oe_n)
        else $error("done pin driven in input mode");

    // ----------------------------------------
    // bus handshake checks
    // ----------------------------------------
    sequence s_aw_taken;
        s_axi_awvalid && s_axi_awready;
    endsequence

    sequence s_w_taken;
        s_axi_wvalid && s_axi_wready;
    endsequence

    sequence s_ar_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence

    // address and data taken together give the response two edges later
    chk_write_answer: assert property (@(posedge clk) disable iff (!arst_n)
        ((s_aw_taken and s_w_taken) ##0 !s_axi_bvalid) |=> ##1 s_axi_bvalid)
        else $error("write response late");
    chk_read_answer: assert property (@(posedge clk) disable iff (!arst_n)
        s_ar_taken |=> s_axi_rvalid) else $error("read response late");
    chk_rd_reserved: assert property (@(posedge clk) disable iff (!arst_n)
        (s_ar_taken ##0 (s_axi_araddr == chan_status_pkg::ADDR_STATUS))
        |=> s_axi_rdata[31:11] == 21'h00_0000) else $error("status reserved bits nonzero");

endmodule : chan_status

`default_nettype wire

// >>> hdl/chan_status_pkg.sv
// constants for the per-channel dma status block
// assumes a single 40 MHz clock and an AXI4-Lite register slave

package chan_status_pkg;

    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam logic [3:0] ADDR_STATUS = 4'h0;
    localparam logic [3:0] ADDR_CONTROL = 4'h4;
    localparam logic [3:0] ADDR_IRQ_MASK = 4'h8;

    // ----------------------------------------
    // status bit positions
    // ----------------------------------------
    localparam int BIT_CHAIN_EN = 10;
    localparam int BIT_STALL = 9;
    localparam int BIT_XFER_ACT = 8;
    localparam int BIT_ERR_DONE = 7;
    localparam int BIT_CHAIN_DONE = 6;
    localparam int BIT_XFER_DONE = 5;
    localparam int BIT_EXT_DONE = 4;
    localparam int BIT_CFG_ERR = 3;
    localparam int BIT_DESC_ERR = 2;
    localparam int BIT_DEST_ERR = 1;
    localparam int BIT_SRC_ERR = 0;
    localparam int NUM_EVENTS = 8;
    localparam int EVT_LSB = 0;

    // ----------------------------------------
    // control bit positions (own control register)
    // ----------------------------------------
    localparam int CTL_CHAIN_EN = 0;
    localparam int CTL_XFER_ACT = 1;
    localparam int CTL_IO_REQ = 2;
    localparam int CTL_DONE_BIDIR = 3;
    localparam int CTL_STALL_LSB = 16;
    localparam int STALL_W = 16;

    // ----------------------------------------
    // reset values and timing
    // ----------------------------------------
    localparam logic [31:0] CONTROL_RST = 32'h0000_0000;
    localparam logic [7:0] MASK_RST = 8'h00;
    localparam int PRESCALE_CYCLES = 64;
    localparam logic [5:0] PRESCALE_LAST = 6'h3f;

endpackage : chan_status_pkg

// >>> hdl/stall_timer.sv
// stall detection counter for one channel
// assumes the owner strobe and config come from logic on clk

`timescale 1ns/1ps
`default_nettype none

module stall_timer (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // control
    input wire logic io_request_mode,
    input wire logic bus_owned,
    input wire logic stall_flag,
    input wire logic [15:0] stall_interval_setting,
    // result
    output logic stall_event
);

    logic [5:0] pre_q;
    logic [15:0] count_q;
    logic tick;
    logic running;

    // counter halts while flag stands, so one stall gives one event
    assign running = io_request_mode && !bus_owned && !stall_flag;
    assign tick = running && (pre_q == chan_status_pkg::PRESCALE_LAST);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pre_q <= 6'h00;
        end else if (!running) begin
            pre_q <= 6'h00;
        end else begin
            pre_q <= pre_q + 6'h01;
        end
    end

    // the interval is given in cycles, so the reload is divided by 64
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            count_q <= 16'h0000;
        end else if (!running) begin
            count_q <= {6'h00, stall_interval_setting[15:6]};
        end else if (tick && count_q != 16'h0000) begin
            count_q <= count_q - 16'h0001;
        end
    end

    assign stall_event = tick && (count_q == 16'h0000);

endmodule : stall_timer

`default_nettype wire

// >>> verification/done_device.sv
// model of the external io device that pulses the done strobe
// assumes the bench resolves the open-drain wire with a pull-up

`timescale 1ns/1ps
`default_nettype none

module done_device (
    // clock
    input wire logic clk,
    // command from the bench
    input wire logic fire,
    // open-drain pull, high while the device holds the pin low
    output logic pull_low
);
    // ----------------------------------------
    // strobe timing
    // ----------------------------------------
    int cnt = 0;

    // four cycles low, longer than the two-flop synchroniser needs
    always @(posedge clk) begin
        if (fire) begin
            cnt <= 4;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
        end
    end

    // released pin floats to the pull-up level
    assign pull_low = (cnt > 0);

endmodule : done_device

`default_nettype wire

// >>> verification/tb.sv
// self-checking bench for the channel status block
// assumes the block answers over axi4-lite and the done pin has a pull-up

`timescale 1ns/1ps
`default_nettype none

module tb;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    localparam logic [3:0] ST = chan_status_pkg::ADDR_STATUS;
    localparam logic [3:0] CT = chan_status_pkg::ADDR_CONTROL;
    localparam logic [3:0] MK = chan_status_pkg::ADDR_IRQ_MASK;
    localparam int EVB [6] = '{6, 5, 3, 2, 1, 0};
    logic clk, arst_n;
    logic [3:0] s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready, bus_owned, done_drive_req;
    logic [5:0] evt;
    logic done_strobe_n_out, done_strobe_oe_n, irq, fire, pull_low;
    int n_fail = 0;
    int tests_run = 0;
    // open-drain wire with pull-up
    wire done_pin = !(pull_low || (!done_strobe_oe_n && !done_strobe_n_out));

    chan_status u_dut (
        .clk, .arst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .bus_owned,
        .chain_done_evt(evt[0]), .xfer_done_evt(evt[1]), .cfg_error_evt(evt[2]),
        .desc_bus_error_evt(evt[3]), .dest_bus_error_evt(evt[4]),
        .src_bus_error_evt(evt[5]), .done_drive_req,
        .done_strobe_n_in(done_pin), .done_strobe_n_out, .done_strobe_oe_n, .irq
    );
    done_device u_dev (.clk(clk), .fire(fire), .pull_low(pull_low));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic finish_test;
        if (n_fail == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw_ok, w_ok;
        aw_ok = 0;
        w_ok = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge clk);
            if (s_axi_awvalid && s_axi_awready) begin
                aw_ok = 1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_ok = 1;
                s_axi_wvalid <= 1'b0;
            end
        end
        s_axi_bready <= 1'b1;
        do @(posedge clk); while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        s_axi_rready <= 1'b1;
        do @(posedge clk); while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge clk);
    endtask : rd

    task automatic wrd(input logic [3:0] a, input logic [31:0] d);
        logic [1:0] r;
        wr(a, d, r);
    endtask : wrd

    task automatic rchk(input logic [3:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        chk(e, d);
    endtask : rchk

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset_map;
        logic [31:0] d;
        logic [1:0] r;
        rchk(ST, 32'h0000_0000);
        rchk(CT, 32'h0000_0000);
        rchk(MK, 32'h0000_0000);
        rd(4'hc, d, r);
        chk(32'h0000_0002, {30'h0, r});
        wr(4'hc, 32'hffff_ffff, r);
        chk(32'h0000_0002, {30'h0, r});
    endtask : t_reset_map

    task automatic t_mirrors;
        wrd(CT, 32'h0000_0003);
        rchk(ST, 32'h0000_0500);
        wrd(ST, 32'hffff_ff80);
        rchk(ST, 32'h0000_0500);
        wrd(CT, 32'h0000_0000);
        rchk(ST, 32'h0000_0000);
    endtask : t_mirrors

    // every event input, w0 ignored, w1 clears
    task automatic t_events;
        logic [31:0] e;
        for (int i = 0; i < 6; i++) begin
            evt[i] <= 1'b1;
            @(posedge clk);
            evt <= 6'h00;
            e = 32'h0000_0001 << EVB[i];
            e[7] = (i > 1);
            rchk(ST, e);
            wrd(ST, 32'h0000_0000);
            rchk(ST, e);
            wrd(ST, e);
            rchk(ST, 32'h0000_0000);
        end
    endtask : t_events

    task automatic t_done;
        fire <= 1'b1;
        @(posedge clk);
        fire <= 1'b0;
        repeat (8) @(posedge clk);
        rchk(ST, 32'h0000_0010);
        wrd(ST, 32'h0000_0010);
        rchk(ST, 32'h0000_0000);
        wrd(CT, 32'h0000_0008);
        done_drive_req <= 1'b1;
        repeat (2) @(posedge clk);
        chk(32'h0000_0000, {31'h0, done_strobe_oe_n});
        done_drive_req <= 1'b0;
        repeat (6) @(posedge clk);
        rchk(ST, 32'h0000_0010);
        wrd(CT, 32'h0000_0000);
        wrd(ST, 32'h0000_0010);
    endtask : t_done

    // interval 128 cycles: not set at 100, set by 300 idle cycles
    task automatic t_stall;
        wrd(CT, 32'h0080_0004);
        bus_owned <= 1'b0;
        repeat (100) @(posedge clk);
        rchk(ST, 32'h0000_0000);
        repeat (200) @(posedge clk);
        bus_owned <= 1'b1;
        rchk(ST, 32'h0000_0200);
        wrd(ST, 32'h0000_0000);
        rchk(ST, 32'h0000_0200);
        wrd(ST, 32'h0000_0200);
        rchk(ST, 32'h0000_0000);
        wrd(CT, 32'h0080_0000);
        bus_owned <= 1'b0;
        repeat (300) @(posedge clk);
        rchk(ST, 32'h0000_0000);
        bus_owned <= 1'b1;
    endtask : t_stall

    task automatic t_irq;
        wrd(MK, 32'h0000_0020);
        rchk(MK, 32'h0000_0020);
        evt[1] <= 1'b1;
        @(posedge clk);
        evt <= 6'h00;
        repeat (2) @(posedge clk);
        chk(32'h0000_0001, {31'h0, irq});
        wrd(MK, 32'h0000_0000);
        chk(32'h0000_0000, {31'h0, irq});
        wrd(MK, 32'h0000_0020);
        chk(32'h0000_0001, {31'h0, irq});
        wrd(ST, 32'h0000_0020);
        chk(32'h0000_0000, {31'h0, irq});
    endtask : t_irq

    // ----------------------------------------
    // clock, reset, sequence, watchdog
    // ----------------------------------------
    initial begin
        clk = 0;
        forever #12.5 clk = ~clk;
    end

    initial begin
        arst_n = 0;
        {s_axi_awaddr, s_axi_wstrb, s_axi_araddr} = '0;
        s_axi_wdata = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        evt = '0;
        fire = 0;
        done_drive_req = 0;
        bus_owned = 1;
        s_axi_wstrb = 4'hf;
        repeat (20) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        t_reset_map();
        t_mirrors();
        t_events();
        t_done();
        t_stall();
        t_irq();
        finish_test();
    end

    // whole run needs well under 3000 cycles
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        finish_test();
    end

endmodule : tb

`default_nettype wire
